// ==== verilog/rtc_alarm_repeat_counter.sv ====
// Alarm repeat block: Avalon-MM registers, enable flag, interrupts
`default_nettype none

module rtc_alarm_repeat_counter
(
   // Clock, power-on reset, other reset, clock enable
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // RTC core connections
   input wire logic alarm_match_in,
   input wire logic module_on_in,
   input wire logic alarm_sync_status_in,
   output logic alarm_event_out,
   output logic alarm_enable_flag_out,
   // Interrupt
   output logic irq_out
);

   logic ack_reg;
   logic indefinite_repeat_reg;
   logic enable_reg;
   logic [2:0] status_reg;
   logic [2:0] mask_reg;
   logic [31:0] rdata_reg;
   logic [7:0] count;
   logic clear_enable;
   logic wr_ctrl;
   logic wr_mask;
   logic rd_take;
   logic rd_status;
   logic load_count;
   logic [31:0] ctrl_view;
   logic [31:0] rdata_next;
   logic [2:0] events;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle so read data comes from a flop
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
   assign rd_take = ce_in && avs_read_in && !ack_reg;
   assign rd_status = rd_take && (avs_address_in == alarm_repeat_pkg::ADDR_STATUS);
   assign wr_ctrl = ce_in && avs_write_in && ack_reg && (avs_address_in == alarm_repeat_pkg::ADDR_ALARM_CTRL);
   assign wr_mask = ce_in && avs_write_in && ack_reg && (avs_address_in == alarm_repeat_pkg::ADDR_MASK);
   // Count lane only loads when its byte is enabled
   assign load_count = wr_ctrl && avs_byteenable_in[0];

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ack_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         ack_reg <= !sys_rst_in && (avs_read_in || avs_write_in) && !ack_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter and event generator
   alarm_repeat_count u_count
   (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .match_in(alarm_match_in),
      .enable_in(enable_reg),
      .indefinite_repeat_in(indefinite_repeat_reg),
      .load_in(load_count),
      .load_value_in(avs_writedata_in[7:0]),
      .count_out(count),
      .event_out(alarm_event_out),
      .clear_enable_out(clear_enable)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Alarm control fields: untouched by the non-power-on reset
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         indefinite_repeat_reg <= alarm_repeat_pkg::INDEFINITE_REPEAT_RESET;
      end
      else if (wr_ctrl && avs_byteenable_in[1])
      begin
         indefinite_repeat_reg <= avs_writedata_in[alarm_repeat_pkg::INDEFINITE_REPEAT_BIT];
      end
   end

   // Hardware clear beats a same-cycle software set of the enable
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         enable_reg <= alarm_repeat_pkg::ENABLE_RESET;
      end
      else if (ce_in)
      begin
         if (clear_enable)
         begin
            enable_reg <= 1'b0;
         end
         else if (wr_ctrl && avs_byteenable_in[1])
         begin
            enable_reg <= avs_writedata_in[alarm_repeat_pkg::ENABLE_BIT];
         end
      end
   end

   assign alarm_enable_flag_out = enable_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky events; a new event wins over the read that clears
   always_comb
   begin
      events = alarm_repeat_pkg::EVT_RESET;
      events[alarm_repeat_pkg::EVT_ALARM_BIT] = alarm_match_in && enable_reg;
      events[alarm_repeat_pkg::EVT_DONE_BIT] = clear_enable;
      // Flags a count write in the unsafe window
      events[alarm_repeat_pkg::EVT_COLLIDE_BIT] = load_count && module_on_in && alarm_sync_status_in;
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         status_reg <= alarm_repeat_pkg::EVT_RESET;
      end
      else if (ce_in)
      begin
         if (sys_rst_in)
         begin
            status_reg <= alarm_repeat_pkg::EVT_RESET;
         end
         else
         begin
            status_reg <= (rd_status ? alarm_repeat_pkg::EVT_RESET : status_reg) | events;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         mask_reg <= alarm_repeat_pkg::MASK_RESET;
      end
      else if (ce_in)
      begin
         if (sys_rst_in)
         begin
            mask_reg <= alarm_repeat_pkg::MASK_RESET;
         end
         else if (wr_mask && avs_byteenable_in[0])
         begin
            mask_reg <= avs_writedata_in[alarm_repeat_pkg::EVT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         irq_out <= 1'b0;
      end
      else if (ce_in)
      begin
         irq_out <= |(status_reg & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, captured on the first cycle of a read
   always_comb
   begin
      ctrl_view = 32'h0000_0000;
      ctrl_view[alarm_repeat_pkg::COUNT_LSB +: alarm_repeat_pkg::COUNT_W] = count;
      ctrl_view[alarm_repeat_pkg::INDEFINITE_REPEAT_BIT] = indefinite_repeat_reg;
      ctrl_view[alarm_repeat_pkg::ENABLE_BIT] = enable_reg;
      // Sync status is only trustworthy if the read finishes quickly
      ctrl_view[alarm_repeat_pkg::SYNC_BIT] = alarm_sync_status_in;
   end

   always_comb
   begin
      unique case (avs_address_in)
         alarm_repeat_pkg::ADDR_ALARM_CTRL: rdata_next = ctrl_view;
         alarm_repeat_pkg::ADDR_STATUS: rdata_next = {29'h0000_0000, status_reg};
         alarm_repeat_pkg::ADDR_MASK: rdata_next = {29'h0000_0000, mask_reg};
         default: rdata_next = alarm_repeat_pkg::UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rdata_reg <= 32'h0000_0000;
      end
      else if (rd_take)
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign avs_readdata_out = rdata_reg;

endmodule : rtc_alarm_repeat_counter

`default_nettype wire

// ==== verilog/alarm_repeat_pkg.sv ====
// Constants and register map of the alarm repeat counter block
`default_nettype none

package alarm_repeat_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [3:0] ADDR_ALARM_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // Alarm control field layout
   localparam int COUNT_LSB = 0;
   localparam int COUNT_W = 8;
   localparam int INDEFINITE_REPEAT_BIT = 8;
   localparam int ENABLE_BIT = 9;
   localparam int SYNC_BIT = 10;

   // Status and mask field layout
   localparam int EVT_ALARM_BIT = 0;
   localparam int EVT_DONE_BIT = 1;
   localparam int EVT_COLLIDE_BIT = 2;
   localparam int EVT_W = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and special counts
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] COUNT_WRAP = 8'hff;
   localparam logic [7:0] COUNT_STEP = 8'h01;
   localparam logic INDEFINITE_REPEAT_RESET = 1'h0;
   localparam logic ENABLE_RESET = 1'h0;
   localparam logic [2:0] EVT_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : alarm_repeat_pkg

`default_nettype wire

// ==== verilog/alarm_repeat_count.sv ====
// Repeat counter and alarm event generator
`default_nettype none

module alarm_repeat_count
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Alarm source and settings
   input wire logic match_in,
   input wire logic enable_in,
   input wire logic indefinite_repeat_in,
   // Software load of the count
   input wire logic load_in,
   input wire logic [7:0] load_value_in,
   // Results
   output logic [7:0] count_out,
   output logic event_out,
   output logic clear_enable_out
);

   logic alarm_now;
   logic at_zero;

   assign alarm_now = match_in && enable_in;
   assign at_zero = (count_out == alarm_repeat_pkg::COUNT_ZERO);
   assign clear_enable_out = alarm_now && at_zero && !indefinite_repeat_in;

   ////////////////////////////////////////////////////////////////////////////
   // Count: power-on reset only; software load beats a same-cycle alarm
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         count_out <= alarm_repeat_pkg::COUNT_RESET;
      end
      else if (ce_in)
      begin
         if (load_in)
         begin
            count_out <= load_value_in;
         end
         else if (alarm_now)
         begin
            if (!at_zero)
            begin
               count_out <= count_out - alarm_repeat_pkg::COUNT_STEP;
            end
            else if (indefinite_repeat_in)
            begin
               count_out <= alarm_repeat_pkg::COUNT_WRAP;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event, registered: high in the cycle after each cycle of an enabled match, so it stays high while the match is held with enable_in set
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         event_out <= 1'b0;
      end
      else if (ce_in)
      begin
         event_out <= alarm_now;
      end
   end

endmodule : alarm_repeat_count

`default_nettype wire

// ==== verif/rtc_alarm_repeat_counter_chk.sv ====
// Port checker of the alarm repeat block
`default_nettype none

module rtc_alarm_repeat_counter_chk
(
   // Clock and resets
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Bus and alarm signals
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire logic alarm_match_in,
   input wire logic alarm_event_out,
   input wire logic alarm_enable_flag_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_hit;
      alarm_match_in && alarm_enable_flag_out && ce_in;
   endsequence
   sequence s_ack;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence

   property p_evt;
      s_hit |=> alarm_event_out;
   endproperty
   a_evt: assert property (p_evt) else $error("no event after enabled match");
   property p_quiet;
      ce_in && !(alarm_match_in && alarm_enable_flag_out) |=> !alarm_event_out;
   endproperty
   a_quiet: assert property (p_quiet) else $error("event without enabled match");
   // A software write may also drop the flag
   property p_clr;
      $fell(alarm_enable_flag_out) && !$past(avs_write_in) |-> alarm_event_out;
   endproperty
   a_clr: assert property (p_clr) else $error("enable dropped without alarm");
   property p_stay;
      !alarm_enable_flag_out && !avs_write_in |=> !alarm_enable_flag_out;
   endproperty
   a_stay: assert property (p_stay) else $error("enable set without write");
   property p_sys;
      sys_rst_in && ce_in && !avs_write_in && !alarm_match_in |=> $stable(alarm_enable_flag_out);
   endproperty
   a_sys: assert property (p_sys) else $error("other reset touched enable");
   property p_wait;
      $rose(avs_write_in) && ce_in && !sys_rst_in |-> s_ack;
   endproperty
   a_wait: assert property (p_wait) else $error("write not acknowledged after one wait");
endmodule : rtc_alarm_repeat_counter_chk

bind rtc_alarm_repeat_counter rtc_alarm_repeat_counter_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
   .sys_rst_in(sys_rst_in), .ce_in(ce_in), .avs_write_in(avs_write_in),
   .avs_waitrequest_out(avs_waitrequest_out), .alarm_match_in(alarm_match_in),
   .alarm_event_out(alarm_event_out), .alarm_enable_flag_out(alarm_enable_flag_out));

`default_nettype wire

// ==== verif/rtc_alarm_repeat_counter_tb_top.sv ====
// Self-checking bench of the alarm repeat block
`default_nettype none

module rtc_alarm_repeat_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] c; logic ch; int n; logic [7:0] ec; logic en; int ev;} row_t;
   logic clk_in, rstn_in, sys_rst_in, ce_in, rd, wr, match, on, sync, wait_o, ev, en, irq;
   logic [3:0] adr, be;
   logic [31:0] wd, rdata, q;
   int bad_count = 0, n_checks = 0, cyc = 0, evs = 0;
   // Count, indefinite_repeat, matches, final count, final enable, events
   row_t rows[6] = '{'{8'h02, 1'b0, 2, 8'h00, 1'b1, 2}, '{8'h02, 1'b0, 4, 8'h00, 1'b0, 3},
      '{8'h00, 1'b0, 2, 8'h00, 1'b0, 1}, '{8'h00, 1'b1, 2, 8'hfe, 1'b1, 2},
      '{8'hff, 1'b0, 300, 8'h00, 1'b0, 256}, '{8'h01, 1'b1, 258, 8'hff, 1'b1, 258}};

   rtc_alarm_repeat_counter uut (.clk_in(clk_in), .rstn_in(rstn_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
      .alarm_match_in(match), .module_on_in(on), .alarm_sync_status_in(sync), .alarm_event_out(ev),
      .alarm_enable_flag_out(en), .irq_out(irq));

   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // Also cuts a hang short
   always @(posedge clk_in)
   begin
      if (ev === 1'b1) evs++;
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         test_done();
      end
   end

   ///////////////////////////////////////////////////////////////////
   task test_done();
      if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         bad_count++;
      end
   endtask : chk

   // Idle cycle after release so requests never merge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      @(posedge clk_in);
      // Only the cycle ceiling may end a stuck wait
      while (wait_o !== 1'b0)
      begin
         @(posedge clk_in);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_in);
   endtask : bus

   task rdchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask : rdchk

   task hits(input int n);
      match <= 1'b1;
      repeat (n) @(posedge clk_in);
      match <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask : hits

   ///////////////////////////////////////////////////////////////////
   initial
   begin
      {rstn_in, sys_rst_in, rd, wr, match, on, sync, adr, wd} = '0;
      ce_in = 1'b1;
      be = 4'hf;
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      rdchk(4'h0, 32'h0000_0000);
      foreach (rows[i])
      begin
         bus(1'b1, 4'h0, {22'h0, 1'b1, rows[i].ch, rows[i].c});
         evs = 0;
         hits(rows[i].n);
         chk(evs, rows[i].ev);
         rdchk(4'h0, {22'h0, rows[i].en, rows[i].ch, rows[i].ec});
      end
      rdchk(4'h4, 32'h0000_0003);
      // Masked event, then unmasked, then cleared by read
      bus(1'b1, 4'h0, 32'h0000_0201);
      hits(1);
      chk(irq, 1'b0);
      bus(1'b1, 4'h8, 32'h0000_0007);
      repeat (2) @(posedge clk_in);
      chk(irq, 1'b1);
      rdchk(4'h4, 32'h0000_0001);
      repeat (2) @(posedge clk_in);
      chk(irq, 1'b0);
      hits(1);
      chk(en, 1'b0);
      rdchk(4'h4, 32'h0000_0003);
      // Count write while busy, one byte lane only
      on <= 1'b1;
      sync <= 1'b1;
      be <= 4'h1;
      bus(1'b1, 4'h0, 32'hffff_ff55);
      be <= 4'hf;
      rdchk(4'h0, 32'h0000_0455);
      rdchk(4'h4, 32'h0000_0004);
      on <= 1'b0;
      sync <= 1'b0;
      bus(1'b1, 4'hc, 32'hffff_ffff);
      rdchk(4'hc, 32'h0000_0000);
      // Clock enable low freezes count and event
      bus(1'b1, 4'h0, 32'h0000_0203);
      evs = 0;
      ce_in <= 1'b0;
      hits(2);
      ce_in <= 1'b1;
      chk(evs, 0);
      rdchk(4'h0, 32'h0000_0203);
      // Other reset keeps control, clears mask
      bus(1'b1, 4'h0, 32'h0000_0209);
      sys_rst_in <= 1'b1;
      @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rdchk(4'h0, 32'h0000_0209);
      rdchk(4'h8, 32'h0000_0000);
      rstn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      rdchk(4'h0, 32'h0000_0000);
      test_done();
   end
endmodule : rtc_alarm_repeat_counter_tb_top

`default_nettype wire
